// *** lcd_ctrl_model.sv ***
`timescale 1ns/1ps
module lcd_ctrl_model (
	input wire logic clk,
	output logic row_shift_clock,
	output logic scan_bit,
	output logic ac_polarity
);
	// --------------------------------------------------------
	// Scan controller on the far side of the row pins
	// --------------------------------------------------------
	// Each phase is long enough to clear the pin synchronisers
	localparam int PHASE = 4;

	// Shift clock stands high between frames, no free running
	initial begin
		row_shift_clock = 1'b1;
		scan_bit = 1'b0;
		ac_polarity = 1'b1;
	end

	// One row period: data set while high, then a fall and a rise
	task automatic shift(input logic b);
		@(posedge clk);
		scan_bit <= b;
		repeat (PHASE) @(posedge clk);
		row_shift_clock <= 1'b0;
		repeat (PHASE) @(posedge clk);
		row_shift_clock <= 1'b1;
		repeat (PHASE) @(posedge clk);
	endtask

	// Frame of 64 to 300 rows with a single leading high bit
	task automatic frame(input int rows);
		shift(1'b1);
		repeat (rows - 1) shift(1'b0);
	endtask

	// Polarity flips between rows, as in normal frame inversion
	task automatic set_pol(input logic p);
		@(posedge clk);
		ac_polarity <= p;
	endtask
endmodule // lcd_ctrl_model

// *** lcd_row_pkg.sv ***
package lcd_row_pkg;

	// ----------------------------------------------------------------
	// Scan chain geometry and drive levels
	// ----------------------------------------------------------------
	localparam int ROW_COUNT = 100;
	localparam int ROW_IDX_W = 7;
	localparam logic [6:0] NO_ROW = 7'h7f;
	localparam logic [1:0] LVL_TOP = 2'h0;
	localparam logic [1:0] LVL_NSEL_HIGH = 2'h1;
	localparam logic [1:0] LVL_NSEL_LOW = 2'h2;
	localparam logic [1:0] LVL_SEL_FAR = 2'h3;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and reset values
	// ----------------------------------------------------------------
	localparam int APB_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ROWSEL = 8'h08;
	localparam logic [7:0] OFS_LOG = 8'h0c;
	localparam logic [7:0] OFS_DROPS = 8'h10;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int CTRL_BLANK_BIT = 0;
	localparam int CTRL_LOG_BIT = 1;
	localparam logic [15:0] DROPS_RESET = 16'h0000;
	localparam logic [5:0] PINS_RESET = 6'h00;

	// ----------------------------------------------------------------
	// Scan log buffer
	// ----------------------------------------------------------------
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 16;

	typedef logic [1:0] level_t;

	// Pin inputs, synchronised as one bundle
	typedef struct packed {
		logic scl;
		logic blank_n;
		logic dir;
		logic pol;
		logic a_in;
		logic b_in;
	} pins_t;

	// One scan log entry, written after each shift while the log bit is set and the buffer has room
	typedef struct packed {
		logic [20:0] reserved;
		logic dir;
		logic pol;
		logic blanked;
		logic sel_valid;
		logic [6:0] row_idx;
	} log_word_t;

endpackage

// *** lcd_row_scan_driver.sv ***
`timescale 1ns/1ps
module lcd_row_scan_driver
	import lcd_row_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	// Row scan pins
	input wire logic row_shift_clock,
	input wire logic blank_n,
	input wire logic shift_dir_sel,
	input wire logic ac_polarity,
	input wire logic serial_io_a_in,
	output logic serial_io_a_out,
	output logic serial_io_a_oe,
	input wire logic serial_io_b_in,
	output logic serial_io_b_out,
	output logic serial_io_b_oe,
	output level_t [ROW_COUNT-1:0] row_outputs,
	// APB slave
	input wire logic [APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------

	// Lowest selected row, or NO_ROW when the chain is empty
	function automatic logic [ROW_IDX_W-1:0] first_set(input logic [ROW_COUNT-1:0] v);
		logic [ROW_IDX_W-1:0] idx;
		idx = NO_ROW;
		for (int i = ROW_COUNT - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = ROW_IDX_W'(i);
			end
		end
		return idx;
	endfunction

	// Drive level of one row from its stage, polarity and blanking
	function automatic level_t level_of(input logic stage, input logic pol, input logic blank);
		level_t lv;
		lv = LVL_TOP;
		if (blank) begin
			lv = LVL_TOP;
		end else if (stage) begin
			lv = pol ? LVL_SEL_FAR : LVL_TOP;
		end else begin
			lv = pol ? LVL_NSEL_HIGH : LVL_NSEL_LOW;
		end
		return lv;
	endfunction

	// Register address recognised by the slave
	function automatic logic is_mapped(input logic [APB_AW-1:0] a);
		return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_ROWSEL) ||
			(a == OFS_LOG) || (a == OFS_DROPS);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	pins_t pins_raw;
	pins_t pins_s;
	logic scl_d_reg;
	logic fall_evt;
	logic blanked;

	assign pins_raw = '{scl: row_shift_clock, blank_n: blank_n, dir: shift_dir_sel,
		pol: ac_polarity, a_in: serial_io_a_in, b_in: serial_io_b_in};

	// Every pin crosses two flops before any logic sees it
	pin_sync #(
		.WIDTH(6)
	) u_sync (
		.clk(clk),
		.resetn(resetn),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	// Falling edge of the synchronised shift clock
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_d_reg <= 1'b0;
		end else begin
			scl_d_reg <= pins_s.scl;
		end
	end

	assign fall_evt = scl_d_reg && !pins_s.scl;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic [1:0] ctrl_reg;
	logic [15:0] drops_reg;

	// Software blank adds to the pin; it cannot cancel it
	assign blanked = !pins_s.blank_n || ctrl_reg[CTRL_BLANK_BIT];

	// ----------------------------------------------------------------
	// Shift chain
	// ----------------------------------------------------------------
	logic [ROW_COUNT-1:0] stage_reg;
	logic [ROW_COUNT-1:0] stage_next;

	// Data and clock are synchronised together, so their skew stays put
	always_comb begin
		stage_next = stage_reg;
		if (blanked) begin
			stage_next = '0;
		end else if (fall_evt) begin
			if (pins_s.dir) begin
				stage_next = {pins_s.b_in, stage_reg[ROW_COUNT-1:1]};
			end else begin
				stage_next = {stage_reg[ROW_COUNT-2:0], pins_s.a_in};
			end
		end
	end

	// One stage per row, moved on a shift edge and cleared while blanked
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage_reg <= '0;
		end else begin
			stage_reg <= stage_next;
		end
	end

	// Serial out follows the far stage; clearing by blank is the only other change
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			serial_io_a_out <= 1'b0;
			serial_io_b_out <= 1'b0;
		end else if (blanked) begin
			serial_io_a_out <= 1'b0;
			serial_io_b_out <= 1'b0;
		end else if (fall_evt) begin
			serial_io_a_out <= stage_next[0];
			serial_io_b_out <= stage_next[ROW_COUNT-1];
		end
	end

	// Pin roles follow the direction select
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			serial_io_a_oe <= 1'b0;
			serial_io_b_oe <= 1'b0;
		end else begin
			serial_io_a_oe <= pins_s.dir;
			serial_io_b_oe <= !pins_s.dir;
		end
	end

	// ----------------------------------------------------------------
	// Row drive levels
	// ----------------------------------------------------------------
	// Stages move on shift edges and clear while blanked; levels follow them one cycle later
	generate
		for (genvar r = 0; r < ROW_COUNT; r++) begin : g_row
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					row_outputs[r] <= LVL_TOP;
				end else begin
					row_outputs[r] <= level_of(stage_reg[r], pins_s.pol, blanked);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Scan log
	// ----------------------------------------------------------------
	logic push_pend_reg;
	logic log_ready;
	logic log_valid;
	logic log_pop;
	log_word_t log_in;
	logic [FIFO_WIDTH-1:0] log_out;
	logic [4:0] log_level;
	logic [ROW_IDX_W-1:0] sel_idx;

	assign sel_idx = first_set(stage_reg);

	// Entry is built one cycle after the shift, from the moved chain
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			push_pend_reg <= 1'b0;
		end else begin
			push_pend_reg <= fall_evt && ctrl_reg[CTRL_LOG_BIT];
		end
	end

	always_comb begin
		log_in = '0;
		log_in.dir = pins_s.dir;
		log_in.pol = pins_s.pol;
		log_in.blanked = blanked;
		log_in.sel_valid = (sel_idx != NO_ROW);
		log_in.row_idx = sel_idx;
	end

	log_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_log (
		.clk(clk),
		.resetn(resetn),
		.in_valid(push_pend_reg),
		.in_ready(log_ready),
		.in_data(log_in),
		.out_valid(log_valid),
		.out_ready(log_pop),
		.out_data(log_out),
		.level(log_level)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	typedef enum logic {APB_IDLE, APB_DONE} apb_state_t;
	apb_state_t apb_state_reg;
	logic apb_take;
	logic apb_commit;
	logic [31:0] rd_value;

	// Access is taken in its first cycle and answered one cycle later
	assign apb_take = (apb_state_reg == APB_IDLE) && psel && penable;
	assign apb_commit = (apb_state_reg == APB_DONE) && psel && penable && pwrite;
	assign log_pop = apb_take && !pwrite && (paddr == OFS_LOG) && log_valid;

	// Read mux; the log word carries its own valid bit in bit 31
	always_comb begin
		rd_value = 32'h0000_0000;
		case (paddr)
			OFS_CTRL: rd_value = {30'h0, ctrl_reg};
			OFS_STATUS: rd_value = {19'h0, log_level, 3'h0, !log_ready, blanked,
				pins_s.pol, pins_s.dir, sel_idx != NO_ROW};
			OFS_ROWSEL: rd_value = {25'h0, sel_idx};
			OFS_LOG: rd_value = log_valid ? {1'b1, log_out[30:0]} : 32'h0000_0000;
			OFS_DROPS: rd_value = {16'h0, drops_reg};
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// Answer handshake; every bus output is a flop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			apb_state_reg <= APB_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			case (apb_state_reg)
				APB_IDLE: begin
					if (apb_take) begin
						apb_state_reg <= APB_DONE;
						pready <= 1'b1;
						pslverr <= !is_mapped(paddr);
						prdata <= pwrite ? 32'h0000_0000 : rd_value;
					end
				end
				APB_DONE: begin
					apb_state_reg <= APB_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					apb_state_reg <= APB_IDLE;
					pready <= 1'b0;
				end
			endcase
		end
	end

	// Control write lands on the edge that completes the transfer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= CTRL_RESET;
		end else if (apb_commit && (paddr == OFS_CTRL) && pstrb[0]) begin
			ctrl_reg <= pwdata[1:0];
		end
	end

	// Lost log entries; a new loss wins over a clearing write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drops_reg <= DROPS_RESET;
		end else if (push_pend_reg && !log_ready) begin
			if (apb_commit && (paddr == OFS_DROPS)) begin
				drops_reg <= 16'h0001;
			end else if (drops_reg != 16'hffff) begin
				drops_reg <= drops_reg + 16'h0001;
			end
		end else if (apb_commit && (paddr == OFS_DROPS)) begin
			drops_reg <= DROPS_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_shift_fwd: assert property (
		@(posedge clk) disable iff (!resetn)
		fall_evt && !blanked && !pins_s.dir |=>
			stage_reg == {$past(stage_reg[ROW_COUNT-2:0]), $past(pins_s.a_in)})
		else $error("forward shift did not take pin a");

	chk_shift_back: assert property (
		@(posedge clk) disable iff (!resetn)
		fall_evt && !blanked && pins_s.dir |=>
			stage_reg == {$past(pins_s.b_in), $past(stage_reg[ROW_COUNT-1:1])})
		else $error("reverse shift did not take pin b");

	chk_stage_hold: assert property (
		@(posedge clk) disable iff (!resetn)
		!fall_evt && !blanked |=> $stable(stage_reg))
		else $error("chain moved without a shift edge");

	chk_level_cause: assert property (
		@(posedge clk) disable iff (!resetn)
		$changed(row_outputs) |-> ($past(stage_reg) != $past(stage_reg, 2)) ||
			($past(pins_s.pol) != $past(pins_s.pol, 2)) || ($past(blanked) != $past(blanked, 2)))
		else $error("row level changed without cause");

	chk_serial_out: assert property (
		@(posedge clk) disable iff (!resetn)
		$changed(serial_io_b_out) |-> $past(fall_evt) || $past(blanked))
		else $error("serial out changed off a shift edge");

	chk_pin_roles: assert property (
		@(posedge clk) disable iff (!resetn)
		$past(resetn) |-> (serial_io_a_oe == $past(pins_s.dir)) && (serial_io_b_oe != serial_io_a_oe))
		else $error("serial pin roles do not follow select");

	chk_blank_all: assert property (
		@(posedge clk) disable iff (!resetn)
		blanked [*2] |-> stage_reg == '0 && row_outputs == '0)
		else $error("blanking did not clear rows");

	chk_select_far: assert property (
		@(posedge clk) disable iff (!resetn)
		!blanked && stage_reg[0] && pins_s.pol |=> row_outputs[0] == LVL_SEL_FAR)
		else $error("selected row not at far level");

	chk_nonsel_low: assert property (
		@(posedge clk) disable iff (!resetn)
		!blanked && !stage_reg[ROW_COUNT-1] && !pins_s.pol |=> row_outputs[ROW_COUNT-1] == LVL_NSEL_LOW)
		else $error("idle row not at lower non-select level");

	chk_apb_answer: assert property (
		@(posedge clk) disable iff (!resetn)
		apb_take |=> pready ##1 !pready)
		else $error("bus answer not one cycle after take");

endmodule // lcd_row_scan_driver

// *** log_fifo.sv ***
`timescale 1ns/1ps
module log_fifo
	import lcd_row_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_reg;
	logic [PW-1:0] rd_reg;
	logic push;
	logic pop;

	// Full and empty come from the true fill count
	assign in_ready = (level != (PW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data = mem[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage has no reset, pointers do
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end

endmodule // log_fifo

// *** pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync
	import lcd_row_pkg::*;
#(
	parameter int WIDTH = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// Two stages; the first one is read by the second only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // pin_sync

// *** test_lcd_row_scan_driver.sv ***
`timescale 1ns/1ps
module test_lcd_row_scan_driver;
	import lcd_row_pkg::*;
	// --------------------------------------------------------
	// Signals
	// --------------------------------------------------------
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic blank_n = 1'b1;
	logic dir = 1'b0;
	logic idle_t = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rsc;
	logic scan_bit;
	logic pol;
	logic a_out;
	logic a_oe;
	logic b_out;
	logic b_oe;
	level_t [ROW_COUNT-1:0] rows;
	logic [31:0] rd;
	logic err;
	int errors = 0;
	int check_count = 0;

	// A released pin that is not the scan input toggles each cycle so a stale level cannot pass
	wire logic a_wire = a_oe ? a_out : (!dir ? scan_bit : idle_t);
	wire logic b_wire = b_oe ? b_out : (dir ? scan_bit : idle_t);

	// Clock and idle pattern
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		idle_t <= ~idle_t;
	end

	lcd_ctrl_model i_ctrl (.clk(clk), .row_shift_clock(rsc), .scan_bit(scan_bit), .ac_polarity(pol));
	lcd_row_scan_driver i_dut (.clk(clk), .resetn(resetn), .row_shift_clock(rsc), .blank_n(blank_n),
		.shift_dir_sel(dir), .ac_polarity(pol), .serial_io_a_in(a_wire), .serial_io_a_out(a_out),
		.serial_io_a_oe(a_oe), .serial_io_b_in(b_wire), .serial_io_b_out(b_out), .serial_io_b_oe(b_oe),
		.row_outputs(rows), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------
	task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Expected row levels; sel of -1 means no row selected
	function automatic logic [255:0] exp_rows(input int sel, input logic p, input logic blank);
		level_t [ROW_COUNT-1:0] v;
		for (int i = 0; i < ROW_COUNT; i++) begin
			if (blank)
				v[i] = LVL_TOP;
			else if (i == sel)
				v[i] = p ? LVL_SEL_FAR : LVL_TOP;
			else
				v[i] = p ? LVL_NSEL_HIGH : LVL_NSEL_LOW;
		end
		return 256'(v);
	endfunction

	// APB transfer; the request holds until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// No wait limit here; a missing answer is left to the watchdog
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------
	task automatic t_reset();
		chk(rows, 0);
		chk({a_oe, b_oe, pready}, 3'h0);
		resetn <= 1'b1;
		cyc(6);
		chk(rows, exp_rows(-1, 1'b1, 1'b0));
		chk({a_oe, b_oe}, 2'h1);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, CTRL_RESET);
		apb(1'b0, OFS_DROPS, 32'h0);
		chk(rd, DROPS_RESET);
		apb(1'b1, OFS_STATUS, 32'hffffffff);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h4);
		apb(1'b1, OFS_ROWSEL, 32'h0);
		apb(1'b0, OFS_ROWSEL, 32'h0);
		chk(rd, NO_ROW);
		// Control write with its byte lane off must not land
		pstrb <= 4'h0;
		apb(1'b1, OFS_CTRL, 32'h3);
		chk({err, rd}, 33'h0);
		pstrb <= 4'hf;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, CTRL_RESET);
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		$display("test reset done");
	endtask

	// Full frame in one direction, with a polarity swap on the first row
	task automatic t_scan(input logic d);
		int sel;
		dir <= d;
		cyc(6);
		chk({a_oe, b_oe}, d ? 2'h2 : 2'h1);
		for (int k = 1; k <= ROW_COUNT + 1; k++) begin
			i_ctrl.shift(k == 1);
			sel = (k > ROW_COUNT) ? -1 : (d ? ROW_COUNT - k : k - 1);
			chk(rows, exp_rows(sel, 1'b1, 1'b0));
			chk(d ? a_out : b_out, k == ROW_COUNT);
			if (k == 1) begin
				i_ctrl.set_pol(1'b0);
				cyc(5);
				chk(rows, exp_rows(sel, 1'b0, 1'b0));
				i_ctrl.set_pol(1'b1);
				cyc(5);
			end
			if (k == 50) begin
				apb(1'b0, OFS_ROWSEL, 32'h0);
				chk(rd, sel);
			end
		end
		$display("test scan done");
	endtask

	// Blanking from the pin in mid-frame, then from software
	task automatic t_blank();
		dir <= 1'b0;
		cyc(6);
		i_ctrl.shift(1'b1);
		i_ctrl.shift(1'b0);
		blank_n <= 1'b0;
		cyc(5);
		chk(rows, exp_rows(-1, 1'b1, 1'b1));
		i_ctrl.shift(1'b1);
		chk({rows, b_out}, {exp_rows(-1, 1'b1, 1'b1), 1'b0});
		blank_n <= 1'b1;
		cyc(5);
		chk(rows, exp_rows(-1, 1'b1, 1'b0));
		apb(1'b0, OFS_ROWSEL, 32'h0);
		chk(rd, NO_ROW);
		i_ctrl.shift(1'b1);
		apb(1'b1, OFS_CTRL, 32'h1);
		cyc(5);
		chk(rows, exp_rows(-1, 1'b1, 1'b1));
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[3:0], 4'hc);
		apb(1'b1, OFS_CTRL, 32'h0);
		blank_n <= 1'b0;
		cyc(5);
		blank_n <= 1'b1;
		cyc(5);
		$display("test blank done");
	endtask

	// Log buffer filled past full, then drained until empty
	task automatic t_log();
		apb(1'b1, OFS_CTRL, 32'h2);
		for (int k = 0; k < FIFO_DEPTH + 4; k++)
			i_ctrl.shift(k == 0);
		apb(1'b0, OFS_DROPS, 32'h0);
		chk(rd, 32'h4);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[12:0], {5'h10, 8'h15});
		for (int k = 0; k <= FIFO_DEPTH; k++) begin
			apb(1'b0, OFS_LOG, 32'h0);
			chk(rd, (k < FIFO_DEPTH) ? (32'h80000280 | k) : 32'h0);
		end
		apb(1'b1, OFS_DROPS, 32'h0);
		apb(1'b0, OFS_DROPS, 32'h0);
		chk(rd, DROPS_RESET);
		apb(1'b1, OFS_CTRL, 32'h0);
		$display("test log done");
	endtask

	// --------------------------------------------------------
	// Run control
	// --------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence after six cycles of reset
	initial begin
		repeat (6) @(posedge clk);
		t_reset();
		t_scan(1'b0);
		t_scan(1'b1);
		t_blank();
		t_log();
		close_out();
	end

	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out();
	end
endmodule // test_lcd_row_scan_driver
